// >>> hdl/rftx_pkg.sv
// Purpose: Shared constants and types for the transmitter sequencer
// Assumes: 25 MHz system clock
// Notes:   Lock time is a parameter default of the top module
package rftx_pkg;
   localparam int          CLK_MHZ        = 25;
   localparam int          LOCK_TIME_US   = 1000;
   // Longest lock time as an exact count of whole cycles
   localparam int          LOCK_CYC_DEF   = LOCK_TIME_US * CLK_MHZ;
   localparam int          LOCK_W         = 16;
   localparam logic [6:0]  TUNE_RATIO     = 7'h40;
   localparam logic [6:0]  TUNE_OFF       = 7'h00;
   // Crystal edges per half period of the divided clock
   localparam logic [1:0]  XEDGE_PER_HALF = 2'h2;
   localparam int          SYNC_W         = 4;
   localparam int          BUF_DEPTH      = 2;

   typedef enum logic [3:0]
   {
      ST_IDLE   = 4'h1,
      ST_SETTLE = 4'h2,
      ST_READY  = 4'h4,
      ST_SEND   = 4'h8
   } rftx_state_e;

   typedef struct packed
   {
      logic amp;
      logic cap_closed;
   } rftx_key_s;
endpackage : rftx_pkg

// >>> hdl/rftx_buf.sv
// Purpose: Two-entry buffer for keying words
// Assumes: Same clock domain on both sides
// Notes:   Flush empties it in one cycle
`timescale 1ns/1ns
`default_nettype none
module rftx_buf
(
   // Clock and reset
   input  wire logic            clock,
   input  wire logic            resetn,
   input  wire logic            flush,
   // Filling side
   input  wire logic            in_valid,
   output logic                 in_ready,
   input  wire rftx_pkg::rftx_key_s in_data,
   // Draining side
   output logic                 out_valid,
   input  wire logic            out_ready,
   output rftx_pkg::rftx_key_s  out_data
);
   import rftx_pkg::*;

   rftx_key_s  mem_q [BUF_DEPTH];
   logic       wr_q;
   logic       rd_q;
   logic [1:0] cnt_q;
   logic       push;
   logic       pop;

   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready && !flush;
   assign pop       = out_valid && out_ready && !flush;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
      end
      else if (push)
         mem_q[wr_q] <= in_data;
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'h0;
      end
      else if (flush)
      begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'h0;
      end
      else
      begin
         if (push)
            wr_q <= !wr_q;
         if (pop)
            rd_q <= !rd_q;
         if (push && !pop)
            cnt_q <= cnt_q + 2'h1;
         else if (pop && !push)
            cnt_q <= cnt_q - 2'h1;
      end
   end
endmodule : rftx_buf
`default_nettype wire

// >>> hdl/rftx_seq.sv
// Purpose: Power modes, lock wait, keying and clock output of the transmitter
// Assumes: All pins asynchronous to clock; crystal clock sampled as a level
// Notes:   Keying words pass a two-entry buffer drained when rf_ready is high
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1 - Enable and amplifier line low: everything off, standby.
// R2 - Enable high, amplifier low: oscillator, loop, clock driver on, amp off.
// R3 - Both high: amplifier also on.
// R4 - Lock and stable clock output within one millisecond after enable.
// R5 - Controller waits four milliseconds before adopting the crystal clock.
// R6 - ASK: amp line low four milliseconds, then keyed with data.
// R7 - FSK: wait four milliseconds, then amp line high throughout.
// R8 - FSK data keyed by the open-drain capacitor switch.
// R9 - Switch closed gives lower carrier than switch open.
// R10 - Controller drops amp line first, then enable.
// R11 - Tuned oscillator locks at sixty-four times crystal frequency.
// R12 - Controller clocks its shift unit from the returned clock.
// R13 - Shift unit two-wire for ASK, three-wire for FSK.
// R14 - Controller wakes on its RC oscillator until crystal clock adopted.
// R15 - Clock output runs at one quarter crystal frequency while driver on.
// R16 - Controller times the wait with margin for RC tolerance.
module rftx_seq
#(
   parameter logic [rftx_pkg::LOCK_W-1:0] LOCK_CYC =
      rftx_pkg::LOCK_W'(rftx_pkg::LOCK_CYC_DEF)
)
(
   // Clock and reset
   input  wire logic  clock,
   input  wire logic  resetn,
   // Pins from the controller
   input  wire logic  tx_en_line,
   input  wire logic  amp_on_line,
   input  wire logic  cap_sw_line_n,
   input  wire logic  crystal_osc,
   // RF stage ready for a new keying word
   input  wire logic  rf_ready,
   // Power state
   output logic       standby,
   output logic       osc_run,
   output logic       loop_run,
   output logic       clk_drv,
   output logic       locked,
   output logic [6:0] tune_ratio,
   // Keying and clock out
   output logic       power_amp,
   output logic       carrier_low,
   output logic       clk_out
);
   import rftx_pkg::*;

   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   logic              en_s;
   logic              amp_s;
   logic              cap_s;
   logic              crystal_node_s;
   logic              crystal_node_prev_q;
   logic              xedge;
   rftx_state_e       state_q;
   rftx_state_e       state_d;
   logic [LOCK_W-1:0] lock_cnt_q;
   logic              locked_q;
   logic              standby_q;
   logic              osc_run_q;
   logic              loop_run_q;
   logic              clk_drv_q;
   logic [6:0]        tune_ratio_q;
   logic              power_amp_q;
   logic              carrier_low_q;
   logic              clk_out_q;
   logic [1:0]        xcnt_q;
   rftx_key_s         key_now;
   rftx_key_s         last_q;
   rftx_key_s         pend_q;
   logic              pend_vld_q;
   logic              buf_in_ready;
   logic              buf_out_valid;
   rftx_key_s         buf_out;

   // Two-stage synchronisers for every pin
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++)
      begin : g_sync
         always_ff @(posedge clock or negedge resetn)
         begin
            if (!resetn)
            begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end
            else
            begin
               meta_q[gi] <= (gi == 0) ? tx_en_line :
                             (gi == 1) ? amp_on_line :
                             (gi == 2) ? !cap_sw_line_n : crystal_osc;
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate

   assign en_s    = sync_q[0];
   assign amp_s   = sync_q[1];
   assign cap_s   = sync_q[2];
   assign crystal_node_s  = sync_q[3];
   assign xedge   = crystal_node_s && !crystal_node_prev_q;
   assign key_now = '{amp: amp_s, cap_closed: cap_s};

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:   if (en_s) state_d = ST_SETTLE;
         ST_SETTLE: if (!en_s) state_d = ST_IDLE;
                    else if (lock_cnt_q == LOCK_CYC) state_d = ST_READY;
         ST_READY:  if (!en_s) state_d = ST_IDLE;
                    else if (power_amp_q) state_d = ST_SEND;
         ST_SEND:   if (!en_s) state_d = ST_IDLE;
                    else if (!power_amp_q) state_d = ST_READY;
         default:   state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   // Lock wait counted from the enable rise
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         lock_cnt_q <= '0;
         locked_q   <= 1'b0;
      end
      else if (!en_s)
      begin
         lock_cnt_q <= '0;
         locked_q   <= 1'b0;
      end
      else if (lock_cnt_q != LOCK_CYC)
         lock_cnt_q <= lock_cnt_q + LOCK_W'(1); // R4
      else
         locked_q   <= 1'b1; // R4
   end

   // Power modes follow the enable line; standby also needs the amp line low
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         standby_q    <= 1'b1;
         osc_run_q    <= 1'b0;
         loop_run_q   <= 1'b0;
         clk_drv_q    <= 1'b0;
         tune_ratio_q <= TUNE_OFF;
      end
      else
      begin
         standby_q    <= !en_s && !amp_s; // R1
         osc_run_q    <= en_s; // R2
         loop_run_q   <= en_s; // R2
         clk_drv_q    <= en_s; // R2
         tune_ratio_q <= en_s ? TUNE_RATIO : TUNE_OFF; // R11
      end
   end

   // Keying words enter the buffer on each change while enabled; none are sampled while a pending word waits for room
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         last_q     <= '0;
         pend_q     <= '0;
         pend_vld_q <= 1'b0;
      end
      else if (!en_s)
      begin
         last_q     <= '0;
         pend_vld_q <= 1'b0;
      end
      else if (pend_vld_q && !buf_in_ready)
         pend_vld_q <= 1'b1;
      else if (key_now != last_q)
      begin
         last_q     <= key_now;
         pend_q     <= key_now;
         pend_vld_q <= 1'b1;
      end
      else
         pend_vld_q <= 1'b0;
   end

   rftx_buf u_buf
   (
      .clock     (clock),
      .resetn    (resetn),
      .flush     (!en_s),
      .in_valid  (pend_vld_q),
      .in_ready  (buf_in_ready),
      .in_data   (pend_q),
      .out_valid (buf_out_valid),
      .out_ready (rf_ready),
      .out_data  (buf_out)
   );

   // Amplifier and carrier shift from drained words
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         power_amp_q   <= 1'b0;
         carrier_low_q <= 1'b0;
      end
      else if (!en_s)
      begin
         power_amp_q   <= 1'b0; // R1
         carrier_low_q <= 1'b0;
      end
      else if (buf_out_valid && rf_ready)
      begin
         power_amp_q   <= buf_out.amp; // R3
         carrier_low_q <= buf_out.cap_closed; // R9
      end
   end

   // Quarter-rate clock: toggle every second crystal rising edge
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         crystal_node_prev_q <= 1'b0;
         xcnt_q      <= 2'h0;
         clk_out_q   <= 1'b0;
      end
      else
      begin
         crystal_node_prev_q <= crystal_node_s;
         if (!clk_drv_q)
         begin
            xcnt_q    <= 2'h0;
            clk_out_q <= 1'b0;
         end
         else if (xedge && xcnt_q == XEDGE_PER_HALF - 2'h1)
         begin
            xcnt_q    <= 2'h0;
            clk_out_q <= !clk_out_q; // R15
         end
         else if (xedge)
            xcnt_q <= xcnt_q + 2'h1;
      end
   end

   assign standby     = standby_q;
   assign osc_run     = osc_run_q;
   assign loop_run    = loop_run_q;
   assign clk_drv     = clk_drv_q;
   assign locked      = locked_q;
   assign tune_ratio  = tune_ratio_q;
   assign power_amp   = power_amp_q;
   assign carrier_low = carrier_low_q;
   assign clk_out     = clk_out_q;

   standby_off_a: assert property (@(posedge clock) disable iff (!resetn)
      (!en_s && !amp_s) |=> (standby_q && !osc_run_q && !loop_run_q
                             && !clk_drv_q && !power_amp_q)) // R1
      else $error("standby with a stage still on");

   run_no_amp_a: assert property (@(posedge clock) disable iff (!resetn)
      (en_s && !$past(en_s)) |=> (osc_run_q && loop_run_q && clk_drv_q
                                  && !power_amp_q)) // R2
      else $error("enable did not start the oscillator without amp");

   amp_keyed_a: assert property (@(posedge clock) disable iff (!resetn)
      (en_s && amp_s && rf_ready) [*6] |-> power_amp_q) // R3
      else $error("amplifier not on with both lines high");

   lock_time_a: assert property (@(posedge clock) disable iff (!resetn)
      $rose(locked_q) |-> (lock_cnt_q == LOCK_CYC && $past(en_s))) // R4
      else $error("lock flag out of step with its count");

   carrier_low_a: assert property (@(posedge clock) disable iff (!resetn)
      (en_s && cap_s && rf_ready) [*6] |-> carrier_low_q) // R9
      else $error("closed switch did not lower the carrier");

   tune_ratio_a: assert property (@(posedge clock) disable iff (!resetn)
      en_s |=> (loop_run_q && tune_ratio_q == TUNE_RATIO)) // R11
      else $error("loop running at a wrong ratio");

   send_locked_a: assert property (@(posedge clock) disable iff (!resetn)
      (state_q == ST_SEND) |-> locked_q) // R4
      else $error("keying state reached before lock");

   clk_quarter_a: assert property (@(posedge clock) disable iff (!resetn)
      (clk_drv_q && $changed(clk_out_q)) |->
         ($past(xedge) && $past(xcnt_q) == 2'h1)) // R15
      else $error("clock output toggled off the quarter rate");
endmodule : rftx_seq
`default_nettype wire

// >>> verif/rftx_ctl_model.sv
// Purpose: Controller model driving the transmitter pins
// Assumes: Pins change just after a rising clock edge
// Notes:   Settle wait is the lock time times four plus RC margin
`timescale 1ns/1ns
`default_nettype none
module rftx_ctl_model
#(
   parameter int WAIT_CYC = 100
)
(
   // Clock
   input  wire logic clock,
   // Returned crystal clock into the counter input
   input  wire logic ext_count_input,
   // Pins to the transmitter
   output logic      tx_en_line,
   output logic      amp_on_line,
   output logic      cap_sw_line_n
);
   // Wakes on its own clock with the transmitter off
   initial
   begin
      tx_en_line    = 1'h0;
      amp_on_line   = 1'h0;
      cap_sw_line_n = 1'h1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   // Amp line left as the caller set it through the whole settle wait
   task automatic power_up();
      tx_en_line = 1'h1;
      tick(WAIT_CYC);
   endtask : power_up

   // Amp line carries ASK data; switch carries FSK data
   task automatic key(input logic fsk, input logic bit_v);
      amp_on_line   = fsk | bit_v;
      cap_sw_line_n = ~(fsk & bit_v);
   endtask : key

   // Bit boundaries paced by the returned crystal clock
   task automatic shift_edge();
      @(posedge ext_count_input);
      tick(1);
   endtask : shift_edge

   // Amp first, enable afterwards
   task automatic power_down();
      amp_on_line   = 1'h0;
      cap_sw_line_n = 1'h1;
      tick(4);
      tx_en_line    = 1'h0;
   endtask : power_down
endmodule : rftx_ctl_model
`default_nettype wire

// >>> verif/rftx_seq_tb.sv
// Purpose: Self-checking bench for the transmitter sequencer
// Assumes: Short lock count, free-running crystal at 320 ns
// Notes:   Random keying with receiver stalls, fixed seed
`timescale 1ns/1ns
`default_nettype none
module rftx_seq_tb;
   import rftx_pkg::*;
   localparam int LOCK_N = 20;
   localparam int WAIT_N = 5 * LOCK_N;
   logic       clock;
   logic       resetn;
   logic       crystal_osc;
   logic       rf_ready;
   wire logic  tx_en_line;
   wire logic  amp_on_line;
   wire logic  cap_sw_line_n;
   logic       standby;
   logic       osc_run;
   logic       loop_run;
   logic       clk_drv;
   logic       locked;
   logic [6:0] tune_ratio;
   logic       power_amp;
   logic       carrier_low;
   logic       clk_out;
   int         bad_count;
   int         samples_checked;
   int         seed;
   realtime    t0;
   logic       b;

   initial clock = 1'h0;
   always #20 clock = ~clock;

   // Crystal phase unrelated to the system clock
   initial
   begin
      crystal_osc = 1'h0;
      #7;
      forever #160 crystal_osc = ~crystal_osc;
   end

   rftx_seq #(.LOCK_CYC(LOCK_W'(LOCK_N))) uut
   (
      .clock(clock), .resetn(resetn), .tx_en_line(tx_en_line),
      .amp_on_line(amp_on_line), .cap_sw_line_n(cap_sw_line_n),
      .crystal_osc(crystal_osc), .rf_ready(rf_ready),
      .standby(standby), .osc_run(osc_run), .loop_run(loop_run),
      .clk_drv(clk_drv), .locked(locked), .tune_ratio(tune_ratio),
      .power_amp(power_amp), .carrier_low(carrier_low), .clk_out(clk_out)
   );

   rftx_ctl_model #(.WAIT_CYC(WAIT_N)) ctl
   (
      .clock(clock), .ext_count_input(clk_out), .tx_en_line(tx_en_line),
      .amp_on_line(amp_on_line), .cap_sw_line_n(cap_sw_line_n)
   );

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task automatic chk(input string nm, input logic [6:0] e,
                      input logic [6:0] g);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic summarize();
      $display("Checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : summarize

   initial
   begin
      #200000;
      bad_count++;
      $display("Watchdog expired");
      summarize();
   end

   initial
   begin
      seed = 62;
      bad_count = 0;
      samples_checked = 0;
      resetn = 1'h0;
      rf_ready = 1'h1;
      tick(2);
      chk("standby", 7'h01, 7'(standby));
      chk("tune_ratio", TUNE_OFF, tune_ratio);
      resetn = 1'h1;
      tick(3);
      chk("osc_run", 7'h00, 7'(osc_run));
      // Amp raised while disabled must not key
      ctl.key(1'h0, 1'h1);
      tick(8);
      chk("power_amp", 7'h00, 7'(power_amp));
      chk("clk_drv", 7'h00, 7'(clk_drv));
      ctl.key(1'h0, 1'h0);
      fork
         ctl.power_up();
         begin
            tick(4);
            chk("osc_run", 7'h01, 7'(osc_run));
            chk("loop_run", 7'h01, 7'(loop_run));
            chk("clk_drv", 7'h01, 7'(clk_drv));
            chk("standby", 7'h00, 7'(standby));
            chk("power_amp", 7'h00, 7'(power_amp));
            chk("tune_ratio", TUNE_RATIO, tune_ratio);
            chk("locked", 7'h00, 7'(locked));
            tick(LOCK_N + 2);
            chk("locked", 7'h01, 7'(locked));
         end
      join
      @(posedge clk_out);
      t0 = $realtime;
      @(posedge clk_out);
      t0 = $realtime - t0;
      chk("clk_out_period", 7'h01, 7'(t0 >= 1240 && t0 <= 1320));
      tick(1);
      // Receiver stalled while three changes queue up
      rf_ready = 1'h0;
      ctl.key(1'h0, 1'h1);
      tick(6);
      ctl.key(1'h0, 1'h0);
      tick(6);
      ctl.key(1'h0, 1'h1);
      tick(6);
      chk("power_amp", 7'h00, 7'(power_amp));
      rf_ready = 1'h1;
      tick(12);
      chk("power_amp", 7'h01, 7'(power_amp));
      repeat (24)
      begin
         b = 1'($random(seed));
         ctl.key(1'h0, b);
         rf_ready = 1'h0;
         tick($unsigned($random(seed)) % 8);
         rf_ready = 1'h1;
         tick(8);
         chk("power_amp", 7'(b), 7'(power_amp));
         chk("carrier_low", 7'h00, 7'(carrier_low));
      end
      repeat (24)
      begin
         b = 1'($random(seed));
         ctl.shift_edge();
         ctl.key(1'h1, b);
         tick(8);
         chk("power_amp", 7'h01, 7'(power_amp));
         chk("carrier_low", 7'(b), 7'(carrier_low));
      end
      ctl.power_down();
      tick(4);
      chk("standby", 7'h01, 7'(standby));
      chk("osc_run", 7'h00, 7'(osc_run));
      chk("locked", 7'h00, 7'(locked));
      chk("clk_out", 7'h00, 7'(clk_out));
      chk("power_amp", 7'h00, 7'(power_amp));
      chk("tune_ratio", TUNE_OFF, tune_ratio);
      summarize();
   end
endmodule : rftx_seq_tb
`default_nettype wire
